//--- pigv_gate.sv
// What this block does
// - the primary gate register enables subcode Q on bit 5, subcode R-W on 4, anti-shock overflow on 3, I2C on 2, analog PLL on 1 and DSP shock on 0, bits 7 and 6 unused.
// - the secondary gate register enables bit-clock PLL on bit 5, event detector on 4, error-corrector overflow on 3 and host link on 0, bits 2 and 1 reserved and 7 and 6 unused.
// - the vectors are ffe6 error-corrector overflow, ffe8 event detector, ffea bit-clock PLL, ffec DSP shock and ffee analog PLL.
// - the vectors are fff0 I2C, fff2 anti-shock overflow, fff4 R-W subcode, fff6 Q subcode, fff8 timer, fffa external pin, fffc software trap and fffe reset.
// - taking an interrupt sets the global mask flag automatically and only the return from service clears it.
// - each peripheral holds its request until software writes zero into its own flag, so no request is missed.
// - a cleared gate bit only blocks delivery and the held request is delivered once the bit is set again.
// - both gate registers are read/write at 0077h and 0078h and reset to 00h.
//
// Purpose: gate peripheral requests and hand vector addresses to the core
// Assumes: requests are levels synchronous to clk_sys; core pulses fetch and return
// Notes:   event status bits are set on rising forwarded lines and cleared on read
`timescale 1ns/1ns
module pigv_gate
  import pigv_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata_q,
  // gated peripheral requests
  input  wire logic        subcode_q_request,
  input  wire logic        subcode_rw_request,
  input  wire logic        antishock_overflow_request,
  input  wire logic        i2c_request,
  input  wire logic        analog_pll_request,
  input  wire logic        dsp_shock_request,
  input  wire logic        bit_clock_recovery_request,
  input  wire logic        disturbance_event_request,
  input  wire logic        error_corrector_overflow_request,
  input  wire logic        host_link_request,
  // ungated sources
  input  wire logic        counter_tick_request,
  input  wire logic        external_pin_request,
  input  wire logic        software_trap_request,
  // core handshake
  input  wire logic        core_vector_fetch,
  input  wire logic        core_return,
  // outputs
  output logic      [7:0]  fwd_primary_q,
  output logic      [7:0]  fwd_secondary_q,
  output logic             core_irq_q,
  output logic      [15:0] vector_addr_q,
  output logic             global_mask_q,
  output logic             irq_q
);

  logic [7:0]   gate_pri_q, gate_pri_d;
  logic [7:0]   gate_sec_q, gate_sec_d;
  logic [7:0]   pend_pri, pend_sec;
  logic [7:0]   fwd_pri_d, fwd_sec_d;
  logic [1:0]   ungated_q, ungated_d;
  logic [EVT_W-1:0] evt_stat_q, evt_stat_d;
  logic [EVT_W-1:0] evt_en_q, evt_en_d;
  logic [EVT_W-1:0] evt_set;
  logic [7:0]   rdata_d;
  logic         irq_d;
  logic [NUM_VEC-1:0] vec_req;
  logic [15:0]  vec_sel;
  logic         vec_any;
  logic         maskable_any;
  pigv_state_t  state_q, state_d;
  logic         gmask_d;
  logic [15:0]  vector_d;
  logic         core_irq_d;

  // request flags arranged in gate register layout
  always_comb begin
    pend_pri = BYTE_ZERO;
    pend_sec = BYTE_ZERO;
    pend_pri[PRI_SUB_Q]      = subcode_q_request;
    pend_pri[PRI_SUB_RW]     = subcode_rw_request;
    pend_pri[PRI_ANTISHOCK]  = antishock_overflow_request;
    pend_pri[PRI_I2C]        = i2c_request;
    pend_pri[PRI_ANALOG_PLL] = analog_pll_request;
    pend_pri[PRI_DSP_SHOCK]  = dsp_shock_request;
    pend_sec[SEC_BITCLK]     = bit_clock_recovery_request;
    pend_sec[SEC_DISTURB]    = disturbance_event_request;
    pend_sec[SEC_ECC_OVER]   = error_corrector_overflow_request;
    pend_sec[SEC_HOST_LINK]  = host_link_request;
  end

  // register writes and gating
  always_comb begin
    gate_pri_d = gate_pri_q;
    gate_sec_d = gate_sec_q;
    evt_en_d   = evt_en_q;
    if (reg_wr) begin
      unique case (reg_addr)
        OFF_GATE_PRI:   gate_pri_d = reg_wdata & PRI_USED;
        OFF_GATE_SEC:   gate_sec_d = reg_wdata & SEC_USED;
        OFF_EVT_ENABLE: evt_en_d   = reg_wdata;
        default:        gate_pri_d = gate_pri_q;
      endcase
    end
    // requests stay held by peripherals; gating never clears them
    fwd_pri_d = pend_pri & gate_pri_q;
    fwd_sec_d = pend_sec & gate_sec_q;
    ungated_d = {external_pin_request, counter_tick_request};
  end

  // event status: rising forwarded line sets, read clears, set wins
  always_comb begin
    evt_set    = (fwd_pri_d & ~fwd_primary_q) | (fwd_sec_d & ~fwd_secondary_q);
    evt_stat_d = evt_stat_q;
    if (reg_rd && reg_addr == OFF_EVT_STATUS) begin
      evt_stat_d = BYTE_ZERO;
    end
    evt_stat_d = evt_stat_d | evt_set;
    irq_d      = |(evt_stat_d & evt_en_d);
    rdata_d    = BYTE_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_GATE_PRI:   rdata_d = gate_pri_q;
        OFF_GATE_SEC:   rdata_d = gate_sec_q;
        OFF_EVT_STATUS: rdata_d = evt_stat_q;
        OFF_EVT_ENABLE: rdata_d = evt_en_q;
        default:        rdata_d = BYTE_ZERO;
      endcase
    end
  end

  // vector selection, highest index wins
  always_comb begin
    vec_req = '0;
    vec_req[VEC_ECC_OVER]  = fwd_secondary_q[SEC_ECC_OVER];
    vec_req[VEC_DISTURB]   = fwd_secondary_q[SEC_DISTURB];
    vec_req[VEC_BITCLK]    = fwd_secondary_q[SEC_BITCLK];
    vec_req[VEC_DSP_SHOCK] = fwd_primary_q[PRI_DSP_SHOCK];
    vec_req[VEC_ANA_PLL]   = fwd_primary_q[PRI_ANALOG_PLL];
    vec_req[VEC_I2C]       = fwd_primary_q[PRI_I2C];
    vec_req[VEC_ANTISHOCK] = fwd_primary_q[PRI_ANTISHOCK];
    vec_req[VEC_SUB_RW]    = fwd_primary_q[PRI_SUB_RW];
    vec_req[VEC_SUB_Q]     = fwd_primary_q[PRI_SUB_Q];
    vec_req[VEC_TIMER]     = ungated_q[0];
    vec_req[VEC_EXT_PIN]   = ungated_q[1];
    vec_req[VEC_TRAP]      = software_trap_request;
    maskable_any = |vec_req[VEC_EXT_PIN:VEC_ECC_OVER];
    vec_any = 1'b0;
    vec_sel = VEC_ADDR[VEC_RESET];
    for (int i = 0; i < NUM_VEC; i++) begin
      if (vec_req[i]) begin
        vec_any = 1'b1;
        vec_sel = VEC_ADDR[i];
      end
    end
  end

  // dispatcher: global mask and vector hand-over
  always_comb begin
    state_d    = state_q;
    gmask_d    = global_mask_q;
    vector_d   = vector_addr_q;
    unique case (state_q)
      PIGV_IDLE: begin
        if (core_vector_fetch && vec_any &&
            (!global_mask_q || vec_req[VEC_TRAP])) begin
          vector_d = vec_sel;
          gmask_d  = 1'b1;
          state_d  = PIGV_SERVE;
        end
      end
      PIGV_SERVE: begin
        if (core_return) begin
          gmask_d = 1'b0;
          state_d = PIGV_IDLE;
        end
      end
    endcase
    core_irq_d = (maskable_any && !gmask_d) || (vec_req[VEC_TRAP] && state_d == PIGV_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gate_pri_q      <= GATE_RESET;
      gate_sec_q      <= GATE_RESET;
      fwd_primary_q   <= BYTE_ZERO;
      fwd_secondary_q <= BYTE_ZERO;
      ungated_q       <= '0;
      evt_stat_q      <= BYTE_ZERO;
      evt_en_q        <= BYTE_ZERO;
      reg_rdata_q     <= BYTE_ZERO;
      irq_q           <= 1'b0;
      state_q         <= PIGV_IDLE;
      global_mask_q   <= 1'b0;
      vector_addr_q   <= VEC_ADDR[VEC_RESET];
      core_irq_q      <= 1'b0;
    end else begin
      gate_pri_q      <= gate_pri_d;
      gate_sec_q      <= gate_sec_d;
      fwd_primary_q   <= fwd_pri_d;
      fwd_secondary_q <= fwd_sec_d;
      ungated_q       <= ungated_d;
      evt_stat_q      <= evt_stat_d;
      evt_en_q        <= evt_en_d;
      reg_rdata_q     <= rdata_d;
      irq_q           <= irq_d;
      state_q         <= state_d;
      global_mask_q   <= gmask_d;
      vector_addr_q   <= vector_d;
      core_irq_q      <= core_irq_d;
    end
  end

  // checks
  sequence s_take;
    state_q == PIGV_IDLE && core_vector_fetch && vec_any && !global_mask_q;
  endsequence

  a_fwd_pri_and: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 fwd_primary_q == ($past(pend_pri) & $past(gate_pri_q)))
    else $error("primary forward not gated request");

  a_fwd_sec_and: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 fwd_secondary_q == ($past(pend_sec) & $past(gate_sec_q)))
    else $error("secondary forward not gated request");

  a_pri_unused: assert property (@(posedge clk_sys) disable iff (rst)
    gate_pri_q[7:6] == 2'b00)
    else $error("primary unused bits set");

  a_sec_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    (gate_sec_q & ~SEC_USED) == BYTE_ZERO)
    else $error("secondary reserved bits set");

  a_gate_write: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == OFF_GATE_PRI ##1 reg_rd && reg_addr == OFF_GATE_PRI
    |=> reg_rdata_q == ($past(reg_wdata, 2) & PRI_USED))
    else $error("primary gate readback wrong");

  a_gate_reset: assert property (@(posedge clk_sys)
    rst |=> gate_pri_q == GATE_RESET && gate_sec_q == GATE_RESET)
    else $error("gate registers not cleared by reset");

  a_mask_on_take: assert property (@(posedge clk_sys) disable iff (rst)
    s_take |=> global_mask_q && state_q == PIGV_SERVE)
    else $error("global mask not set on take");

  a_mask_holds: assert property (@(posedge clk_sys) disable iff (rst)
    global_mask_q && !core_return |=> global_mask_q)
    else $error("global mask dropped without return");

  a_vec_table: assert property (@(posedge clk_sys) disable iff (rst)
    s_take and vec_req[NUM_VEC-1:VEC_DISTURB] == '0 and vec_req[VEC_ECC_OVER]
    |=> vector_addr_q == 16'hffe6)
    else $error("overflow vector wrong");

  a_vec_i2c: assert property (@(posedge clk_sys) disable iff (rst)
    s_take and vec_req[NUM_VEC-1:VEC_ANTISHOCK] == '0 and vec_req[VEC_I2C]
    |=> vector_addr_q == 16'hfff0)
    else $error("i2c vector wrong");

  a_pend_kept: assert property (@(posedge clk_sys) disable iff (rst)
    pend_pri[PRI_I2C] && !gate_pri_q[PRI_I2C] ##1
    pend_pri[PRI_I2C] && gate_pri_q[PRI_I2C] |=> fwd_primary_q[PRI_I2C])
    else $error("held request not delivered after unmask");

  sequence s_sec_wr_rd;
    reg_wr && reg_addr == OFF_GATE_SEC ##1 reg_rd && reg_addr == OFF_GATE_SEC;
  endsequence

  a_sec_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_sec_wr_rd |=> reg_rdata_q == ($past(reg_wdata, 2) & SEC_USED))
    else $error("secondary gate readback wrong");

  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> reg_rdata_q == BYTE_ZERO)
    else $error("read data outside read slot");

  a_mask_release: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == PIGV_SERVE && core_return |=> !global_mask_q)
    else $error("global mask kept after return");

  a_irq_blocked: assert property (@(posedge clk_sys) disable iff (rst)
    global_mask_q |-> !core_irq_q)
    else $error("core request raised while masked");

  a_vec_reset: assert property (@(posedge clk_sys)
    rst |=> vector_addr_q == 16'hfffe)
    else $error("reset vector not shown");

  a_vec_stable: assert property (@(posedge clk_sys) disable iff (rst)
    global_mask_q |=> $stable(vector_addr_q))
    else $error("vector changed while serving");

  a_vec_bitclk: assert property (@(posedge clk_sys) disable iff (rst)
    s_take and vec_req[NUM_VEC-1:VEC_DSP_SHOCK] == '0 and vec_req[VEC_BITCLK]
    |=> vector_addr_q == 16'hffea)
    else $error("bit clock vector wrong");

  a_vec_subq: assert property (@(posedge clk_sys) disable iff (rst)
    s_take and vec_req[NUM_VEC-1:VEC_TIMER] == '0 and vec_req[VEC_SUB_Q]
    |=> vector_addr_q == 16'hfff6)
    else $error("q subcode vector wrong");

  a_vec_trap: assert property (@(posedge clk_sys) disable iff (rst)
    s_take and vec_req[VEC_TRAP] |=> vector_addr_q == 16'hfffc)
    else $error("trap vector wrong");

  a_evt_set: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(fwd_primary_q[PRI_I2C]) |-> evt_stat_q[PRI_I2C])
    else $error("event status missed a rising line");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    irq_q == |(evt_stat_q & evt_en_q))
    else $error("interrupt level not status and enable");

endmodule

//--- pigv_pkg.sv
// Purpose: constants shared by the peripheral interrupt gate and vector block
// Assumes: 8-bit register port, 16-bit vector addresses
// Notes:   event status and event enable registers sit in unused register space
package pigv_pkg;
  // register offsets
  localparam logic [7:0] OFF_GATE_PRI   = 8'h77;
  localparam logic [7:0] OFF_GATE_SEC   = 8'h78;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h38;
  localparam logic [7:0] OFF_EVT_ENABLE = 8'h39;

  // reset values and implemented bits
  localparam logic [7:0] GATE_RESET     = 8'h00;
  localparam logic [7:0] PRI_USED       = 8'h3f;
  localparam logic [7:0] SEC_USED       = 8'h39;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;

  // primary gate bit positions
  localparam int PRI_DSP_SHOCK  = 0;
  localparam int PRI_ANALOG_PLL = 1;
  localparam int PRI_I2C        = 2;
  localparam int PRI_ANTISHOCK  = 3;
  localparam int PRI_SUB_RW     = 4;
  localparam int PRI_SUB_Q      = 5;
  // secondary gate bit positions
  localparam int SEC_HOST_LINK  = 0;
  localparam int SEC_ECC_OVER   = 3;
  localparam int SEC_DISTURB    = 4;
  localparam int SEC_BITCLK     = 5;

  // vector table, index 0 lowest priority
  localparam int NUM_VEC = 13;
  localparam int VEC_ECC_OVER  = 0;
  localparam int VEC_DISTURB   = 1;
  localparam int VEC_BITCLK    = 2;
  localparam int VEC_DSP_SHOCK = 3;
  localparam int VEC_ANA_PLL   = 4;
  localparam int VEC_I2C       = 5;
  localparam int VEC_ANTISHOCK = 6;
  localparam int VEC_SUB_RW    = 7;
  localparam int VEC_SUB_Q     = 8;
  localparam int VEC_TIMER     = 9;
  localparam int VEC_EXT_PIN   = 10;
  localparam int VEC_TRAP      = 11;
  localparam int VEC_RESET     = 12;
  localparam logic [15:0] VEC_ADDR [NUM_VEC] = '{
    16'hffe6, 16'hffe8, 16'hffea, 16'hffec, 16'hffee, 16'hfff0, 16'hfff2,
    16'hfff4, 16'hfff6, 16'hfff8, 16'hfffa, 16'hfffc, 16'hfffe};

  // event status layout: bit i is primary forwarded line i ORed with secondary forwarded line i
  localparam int EVT_PRI_LO = 0;
  localparam int EVT_W      = 8;

  typedef enum logic [0:0] {
    PIGV_IDLE  = 1'b0,
    PIGV_SERVE = 1'b1
  } pigv_state_t;
endpackage

//--- pigv_core_model.sv
// Purpose: core that takes a request and returns after ret_wait cycles
// Assumes: fetch and return are one-cycle pulses after the rising edge
// Notes:   no fetch while the core mask flag is up
`timescale 1ns/1ns
module pigv_core_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // from the gate, and ret_wait from the bench
  input  wire logic       core_irq_q,
  input  wire logic       global_mask_q,
  input  wire logic [3:0] ret_wait,
  // to the gate
  output logic            core_vector_fetch = 1'b0,
  output logic            core_return       = 1'b0
);
  logic       busy_q = 1'b0;
  logic [3:0] cnt_q  = 4'h0;
  always @(posedge clk_sys) begin
    if (rst) begin
      busy_q            <= 1'b0;
      core_vector_fetch <= 1'b0;
      core_return       <= 1'b0;
    end else begin
      core_vector_fetch <= !busy_q && core_irq_q && !global_mask_q;
      core_return <= busy_q && cnt_q == 4'h0 && !core_return && global_mask_q;
      if (!busy_q) begin
        if (core_irq_q && !global_mask_q) begin
          busy_q <= 1'b1;
          cnt_q  <= ret_wait;
        end
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (!core_return && !global_mask_q) begin
        // wait for the mask to drop before the next take
        busy_q <= 1'b0;
      end
    end
  end
endmodule

//--- test_peripheral_interrupt_gate_vectors.sv
// Purpose: self-checking bench for the interrupt gate
// Assumes: core model answers every take
// Notes:   req bit i is the source of vector ffe6 + 2*i
`timescale 1ns/1ns
module test_peripheral_interrupt_gate_vectors;
  import pigv_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  ad = 8'h00, wd = 8'h00, rdat, fp, fs;
  logic        wr = 1'b0, rd = 1'b0, hl = 1'b0;
  logic        fet, ret, cirq, gm, irq;
  logic [11:0] req = 12'h000;
  logic [15:0] vec;
  int          error_cnt = 0, compares = 0;
  always #20 clk_sys = ~clk_sys;
  pigv_gate dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(ad),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdat),
    .subcode_q_request(req[8]), .subcode_rw_request(req[7]),
    .antishock_overflow_request(req[6]), .i2c_request(req[5]),
    .analog_pll_request(req[4]), .dsp_shock_request(req[3]),
    .bit_clock_recovery_request(req[2]), .disturbance_event_request(req[1]),
    .error_corrector_overflow_request(req[0]), .host_link_request(hl),
    .counter_tick_request(req[9]), .external_pin_request(req[10]),
    .software_trap_request(req[11]), .core_vector_fetch(fet),
    .core_return(ret), .fwd_primary_q(fp), .fwd_secondary_q(fs),
    .core_irq_q(cirq), .vector_addr_q(vec), .global_mask_q(gm), .irq_q(irq));
  pigv_core_model core_u (.clk_sys(clk_sys), .rst(rst), .core_irq_q(cirq),
    .global_mask_q(gm), .ret_wait(4'h3), .core_vector_fetch(fet),
    .core_return(ret));
  task automatic test_done();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(rdat, exp);
  endtask
  // write then read back with no gap; the read slot closes one cycle later
  task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk_sys);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(rdat, exp);
    step(1);
    chk(rdat, 8'h00);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // wait for a take, check it, release the source, wait for return
  task automatic serve(input logic [15:0] exp);
    for (int n = 0; n < 40 && gm !== 1'b1; n++) step(1);
    chk(gm, 1'b1);
    chk(vec, exp);
    chk(cirq, 1'b0);
    @(posedge clk_sys);
    req <= 12'h000;
    for (int n = 0; n < 40 && gm !== 1'b0; n++) step(1);
    chk(gm, 1'b0);
  endtask
  task automatic sc_regs();
    rdc(OFF_GATE_PRI, 8'h00);
    rdc(OFF_GATE_SEC, 8'h00);
    chk(vec, 16'hfffe);
    wrc(OFF_GATE_PRI, 8'hff, 8'h3f);
    wrc(OFF_GATE_SEC, 8'hff, 8'h39);
    rdc(8'h20, 8'h00);
  endtask
  task automatic sc_hold();
    wrt(OFF_GATE_PRI, 8'h00);
    req <= 12'h020;
    step(4);
    chk(fp, 8'h00);
    chk(gm, 1'b0);
    wrt(OFF_GATE_PRI, 8'h04);
    step(1);
    chk(fp, 8'h04);
    serve(16'hfff0);
  endtask
  task automatic sc_vec();
    wrt(OFF_GATE_PRI, 8'hff);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      req <= 12'h001 << i;
      serve(16'hffe6 + 16'(2 * i));
    end
    @(posedge clk_sys);
    req <= 12'h101;
    serve(16'hfff6);
    @(posedge clk_sys);
    hl <= 1'b1;
    step(2);
    chk(fs, 8'h01);
    @(posedge clk_sys);
    hl <= 1'b0;
    step(8);
  endtask
  task automatic sc_evt();
    rdc(OFF_EVT_STATUS, 8'h3f);
    wrt(OFF_EVT_ENABLE, 8'h00);
    req <= 12'h020;
    step(4);
    chk(irq, 1'b0);
    wrt(OFF_EVT_ENABLE, 8'h04);
    rdc(OFF_EVT_ENABLE, 8'h04);
    step(2);
    chk(irq, 1'b1);
    rdc(OFF_EVT_STATUS, 8'h04);
    step(2);
    chk(irq, 1'b0);
    serve(16'hfff0);
  endtask
  // reset in mid-run after a gate write
  task automatic sc_rst();
    wrt(OFF_GATE_PRI, 8'h2a);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    step(1);
    chk(vec, 16'hfffe);
    chk(gm, 1'b0);
    rdc(OFF_GATE_PRI, 8'h00);
    rdc(OFF_GATE_SEC, 8'h00);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    step(1);
    sc_regs();
    sc_hold();
    sc_vec();
    sc_evt();
    sc_rst();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end
endmodule
